// >>> inc/video_regs_pkg.sv
`default_nettype none

package video_regs_pkg;

    // Read offsets
    localparam logic [7:0] ADDR_DISP_H_CAPTURE = 8'h00;
    localparam logic [7:0] ADDR_COMBINED_STATUS = 8'h01;
    localparam logic [7:0] ADDR_ACQ_V_CAPTURE = 8'h02;
    localparam logic [7:0] ADDR_ACQ_H_CAPTURE = 8'h03;
    localparam logic [7:0] ADDR_DISP_V_CAPTURE = 8'h04;
    localparam logic [7:0] ADDR_INSET_RISE = 8'h08;
    localparam logic [7:0] ADDR_INSET_FALL = 8'h0C;

    // Write offsets
    localparam logic [7:0] ADDR_PEAKING = 8'h13;
    localparam logic [7:0] ADDR_DELAY = 8'h1E;
    localparam logic [7:0] ADDR_PLL = 8'h20;
    localparam logic [7:0] ADDR_CLEAR_BLANK_ACQ = 8'h24;
    localparam logic [7:0] ADDR_SAMPLE = 8'h26;
    localparam logic [7:0] ADDR_CLEAR_BURST = 8'h2C;
    localparam logic [7:0] ADDR_CLEAR_INSET = 8'h2D;
    localparam logic [7:0] ADDR_CLEAR_DISPLAY = 8'h34;
    localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h3D;
    localparam logic [7:0] ADDR_CLAMP_RISE = 8'h3E;
    localparam logic [7:0] ADDR_CLAMP_FALL = 8'h3F;

    // Interrupt and output enable bits
    localparam int IEN_BURST = 1;
    localparam int IEN_INSET = 2;
    localparam int IEN_BLANK = 3;
    localparam int OE_ACQ_RESET = 4;
    localparam int OE_ACQ_CLOCK = 5;
    localparam int OE_DISP_RESET = 6;
    localparam int OE_DISP_CLOCK = 7;

    // Combined status bits
    localparam int ST_BURST = 0;
    localparam int ST_BLANK = 1;
    localparam int ST_INSET = 2;
    localparam int ST_DISPLAY = 3;
    localparam int ST_ACQ_V_MSB = 4;
    localparam int ST_GATE = 5;
    localparam int ST_DISP_V_MSB = 6;

    // Field positions
    localparam int PEAK_A_LSB = 0;
    localparam int PEAK_B_LSB = 2;
    localparam int CORING_LSB = 4;
    localparam int UV_DELAY_LSB = 2;
    localparam int Y_DELAY_LSB = 5;
    localparam int PLL_DIV_LSB = 2;

    // Field decode values
    localparam logic [3:0] UV_DELAY_BASE = 4'h2;
    localparam logic [3:0] Y_DELAY_BASE = 4'h3;
    localparam logic [10:0] PIXELS_CODE0 = 11'h400;
    localparam logic [10:0] PIXELS_CODE1 = 11'h360;
    localparam logic [10:0] PIXELS_CODE2 = 11'h300;
    localparam logic [10:0] PIXELS_CODE3 = 11'h288;

    // Reset values
    localparam logic [7:0] RESET_CONFIG = 8'h00;
    localparam logic [7:0] RESET_CAPTURE = 8'h00;

    typedef struct packed {
        logic [8:0] acq_vertical_counter;
        logic [7:0] acq_horizontal_counter;
        logic [8:0] disp_vertical_counter;
        logic [7:0] disp_horizontal_counter;
    } counters_type;

    typedef struct packed {
        logic burst_blank_irq;
        logic blank_acq_irq;
        logic inset_irq;
        logic display_irq;
    } irq_events_type;

    typedef struct packed {
        logic [3:0] peak_a_eighths;
        logic [3:0] peak_b_eighths;
        logic [3:0] coring_pos;
        logic [3:0] coring_neg;
        logic [3:0] uv_delay;
        logic [3:0] y_delay;
        logic [11:0] clocks_per_line;
    } decoded_type;

endpackage

`default_nettype wire

// >>> hw/field_decode.sv
`default_nettype none

module field_decode
    import video_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Raw fields
    input wire logic [7:0] peaking_cfg,
    input wire logic [7:0] delay_cfg,
    input wire logic [7:0] pll_cfg,
    // Decoded values
    output decoded_type decoded
);

    function automatic logic [3:0] gain_eighths(input logic [1:0] code);
        unique case (code)
            2'b00: gain_eighths = 4'h0;
            2'b01: gain_eighths = 4'h1;
            2'b10: gain_eighths = 4'h2;
            2'b11: gain_eighths = 4'h4;
        endcase
    endfunction

    logic [1:0] coring_code;
    logic [2:0] uv_code;
    logic [2:0] y_code;
    logic [10:0] pixels;

    assign coring_code = peaking_cfg[CORING_LSB +: 2];
    assign uv_code = delay_cfg[UV_DELAY_LSB +: 3];
    assign y_code = delay_cfg[Y_DELAY_LSB +: 3];

    always_comb begin
        unique case (pll_cfg[PLL_DIV_LSB +: 2])
            2'b00: pixels = PIXELS_CODE0;
            2'b01: pixels = PIXELS_CODE1;
            2'b10: pixels = PIXELS_CODE2;
            2'b11: pixels = PIXELS_CODE3;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            decoded <= '0;
        end else begin
            decoded.peak_a_eighths <= gain_eighths(peaking_cfg[PEAK_A_LSB +: 2]);
            decoded.peak_b_eighths <= gain_eighths(peaking_cfg[PEAK_B_LSB +: 2]);
            unique case (coring_code)
                2'b00: begin
                    decoded.coring_pos <= 4'h1;
                    decoded.coring_neg <= 4'h2;
                end
                2'b01: begin
                    decoded.coring_pos <= 4'h3;
                    decoded.coring_neg <= 4'h4;
                end
                2'b10: begin
                    decoded.coring_pos <= 4'h7;
                    decoded.coring_neg <= 4'h8;
                end
                2'b11: begin
                    decoded.coring_pos <= 4'h0;
                    decoded.coring_neg <= 4'h0;
                end
            endcase
            decoded.uv_delay <= 4'({1'b0, uv_code} - UV_DELAY_BASE);
            decoded.y_delay <= 4'({1'b0, y_code} - Y_DELAY_BASE);
            decoded.clocks_per_line <= {pixels, 1'b0};
        end
    end

endmodule

`default_nettype wire

// >>> hw/position_capture_regs.sv
`default_nettype none

module position_capture_regs
    import video_regs_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Multiplexed host bus
    input wire logic [7:0] AD_I,
    output logic [7:0] AD_O,
    output logic AD_OE,
    input wire logic ALE,
    input wire logic WR_N,
    input wire logic RD_N,
    // Timing counters and events
    input wire counters_type COUNTERS,
    input wire logic ACQ_VERTICAL_PULSE,
    input wire logic DISP_VERTICAL_PULSE,
    input wire logic INSET_PICTURE_INPUT,
    input wire irq_events_type IRQ_EVENTS,
    input wire logic GATE_ENABLE,
    input wire logic ACQ_RESET_PULSE,
    input wire logic DISP_RESET_PULSE,
    // Pin drivers
    output logic ACQ_RESET_O,
    output logic ACQ_RESET_OE,
    output logic DISP_RESET_O,
    output logic DISP_RESET_OE,
    output logic ACQ_CLOCK_OE,
    output logic DISP_CLOCK_OE,
    output logic CLAMP_PULSE,
    // Interrupt pins
    output logic ACQ_INTERRUPT_PIN,
    output logic DISP_INTERRUPT_PIN,
    // Decoded configuration
    output decoded_type DECODED
);

    logic [7:0] address;
    logic wr_n_prev;
    logic rd_n_prev;
    logic write_strobe;
    logic read_strobe;

    logic [7:0] irq_enables;
    logic [7:0] clamp_rise;
    logic [7:0] clamp_fall;
    logic [7:0] peaking_cfg;
    logic [7:0] delay_cfg;
    logic [7:0] pll_cfg;

    logic acq_v_prev;
    logic disp_v_prev;
    logic inset_prev;
    logic sample_cmd;
    logic acq_capture;
    logic disp_capture;
    logic inset_rise;
    logic inset_fall;

    logic [7:0] acq_h_cap;
    logic [8:0] acq_v_cap;
    logic [7:0] disp_h_cap;
    logic [8:0] disp_v_cap;
    logic [7:0] inset_rise_cap;
    logic [7:0] inset_fall_cap;

    logic [3:0] pending;
    logic [7:0] status_byte;
    logic [7:0] next_read_data;

    // Address phase
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            address <= 8'h00;
        end else if (ALE) begin
            address <= AD_I;
        end
    end

    // Strobe edges
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            wr_n_prev <= 1'b1;
            rd_n_prev <= 1'b1;
        end else begin
            wr_n_prev <= WR_N;
            rd_n_prev <= RD_N;
        end
    end

    assign write_strobe = wr_n_prev && !WR_N && !ALE;
    assign read_strobe = rd_n_prev && !RD_N && !ALE;

    // Configuration writes
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq_enables <= RESET_CONFIG;
            clamp_rise <= RESET_CONFIG;
            clamp_fall <= RESET_CONFIG;
            peaking_cfg <= RESET_CONFIG;
            delay_cfg <= RESET_CONFIG;
            pll_cfg <= RESET_CONFIG;
        end else if (write_strobe) begin
            unique case (address)
                ADDR_IRQ_ENABLES: irq_enables <= AD_I;
                ADDR_CLAMP_RISE: clamp_rise <= AD_I;
                ADDR_CLAMP_FALL: clamp_fall <= AD_I;
                ADDR_PEAKING: peaking_cfg <= AD_I;
                ADDR_DELAY: delay_cfg <= AD_I;
                ADDR_PLL: pll_cfg <= AD_I;
                default: begin
                end
            endcase
        end
    end

    assign sample_cmd = write_strobe && (address == ADDR_SAMPLE);

    // Edge history
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            acq_v_prev <= 1'b0;
            disp_v_prev <= 1'b0;
            inset_prev <= 1'b0;
        end else begin
            acq_v_prev <= ACQ_VERTICAL_PULSE;
            disp_v_prev <= DISP_VERTICAL_PULSE;
            inset_prev <= INSET_PICTURE_INPUT;
        end
    end

    assign acq_capture = (ACQ_VERTICAL_PULSE && !acq_v_prev) || sample_cmd;
    assign disp_capture = (DISP_VERTICAL_PULSE && !disp_v_prev) || sample_cmd;
    assign inset_rise = INSET_PICTURE_INPUT && !inset_prev;
    assign inset_fall = !INSET_PICTURE_INPUT && inset_prev;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            acq_h_cap <= RESET_CAPTURE;
            acq_v_cap <= {1'b0, RESET_CAPTURE};
        end else if (acq_capture) begin
            acq_h_cap <= COUNTERS.acq_horizontal_counter;
            acq_v_cap <= COUNTERS.acq_vertical_counter;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            disp_h_cap <= RESET_CAPTURE;
            disp_v_cap <= {1'b0, RESET_CAPTURE};
        end else if (disp_capture) begin
            disp_h_cap <= COUNTERS.disp_horizontal_counter;
            disp_v_cap <= COUNTERS.disp_vertical_counter;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            inset_rise_cap <= RESET_CAPTURE;
            inset_fall_cap <= RESET_CAPTURE;
        end else begin
            if (inset_rise) begin
                inset_rise_cap <= COUNTERS.acq_horizontal_counter;
            end
            if (inset_fall) begin
                inset_fall_cap <= COUNTERS.acq_horizontal_counter;
            end
        end
    end

    // Pending interrupts, set wins over clear
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pending <= 4'h0;
        end else begin
            if (IRQ_EVENTS.burst_blank_irq) begin
                pending[ST_BURST] <= 1'b1;
            end else if (write_strobe && address == ADDR_CLEAR_BURST) begin
                pending[ST_BURST] <= 1'b0;
            end
            if (IRQ_EVENTS.blank_acq_irq) begin
                pending[ST_BLANK] <= 1'b1;
            end else if (write_strobe && address == ADDR_CLEAR_BLANK_ACQ) begin
                pending[ST_BLANK] <= 1'b0;
            end
            if (IRQ_EVENTS.inset_irq) begin
                pending[ST_INSET] <= 1'b1;
            end else if (write_strobe && address == ADDR_CLEAR_INSET) begin
                pending[ST_INSET] <= 1'b0;
            end
            if (IRQ_EVENTS.display_irq) begin
                pending[ST_DISPLAY] <= 1'b1;
            end else if (write_strobe && address == ADDR_CLEAR_DISPLAY) begin
                pending[ST_DISPLAY] <= 1'b0;
            end
        end
    end

    // Combined status assembly
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_DISPLAY:ST_BURST] = pending;
        status_byte[ST_ACQ_V_MSB] = acq_v_cap[8];
        status_byte[ST_GATE] = GATE_ENABLE;
        status_byte[ST_DISP_V_MSB] = disp_v_cap[8];
    end

    // Read mux
    always_comb begin
        next_read_data = 8'h00;
        unique case (address[1:0])
            ADDR_ACQ_H_CAPTURE[1:0]: next_read_data = acq_h_cap;
            ADDR_ACQ_V_CAPTURE[1:0]: next_read_data = acq_v_cap[7:0];
            ADDR_COMBINED_STATUS[1:0]: next_read_data = status_byte;
            default: begin
                unique case (address[3:0])
                    ADDR_DISP_H_CAPTURE[3:0]: next_read_data = disp_h_cap;
                    ADDR_DISP_V_CAPTURE[3:0]: next_read_data = disp_v_cap[7:0];
                    ADDR_INSET_RISE[3:0]: next_read_data = inset_rise_cap;
                    ADDR_INSET_FALL[3:0]: next_read_data = inset_fall_cap;
                    default: next_read_data = 8'h00;
                endcase
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            AD_O <= 8'h00;
        end else if (read_strobe) begin
            AD_O <= next_read_data;
        end
    end

    assign AD_OE = !RD_N && !rd_n_prev && !ALE;

    // Clamp pulse edges
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            CLAMP_PULSE <= 1'b0;
        end else if (clamp_rise == COUNTERS.acq_horizontal_counter) begin
            CLAMP_PULSE <= 1'b1;
        end else if (clamp_fall == COUNTERS.acq_horizontal_counter) begin
            CLAMP_PULSE <= 1'b0;
        end
    end

    // Reset pulse drivers
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ACQ_RESET_O <= 1'b0;
            DISP_RESET_O <= 1'b0;
        end else begin
            ACQ_RESET_O <= ACQ_RESET_PULSE;
            DISP_RESET_O <= DISP_RESET_PULSE;
        end
    end

    assign ACQ_CLOCK_OE = irq_enables[OE_ACQ_CLOCK];
    assign DISP_CLOCK_OE = irq_enables[OE_DISP_CLOCK];
    assign DISP_RESET_OE = irq_enables[OE_DISP_RESET];
    assign ACQ_RESET_OE = irq_enables[OE_ACQ_RESET] && !irq_enables[OE_ACQ_CLOCK];

    assign ACQ_INTERRUPT_PIN = (pending[ST_BURST] && irq_enables[IEN_BURST])
        || (pending[ST_INSET] && irq_enables[IEN_INSET])
        || (pending[ST_BLANK] && irq_enables[IEN_BLANK]);
    assign DISP_INTERRUPT_PIN = pending[ST_DISPLAY];

    field_decode u_field_decode (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .peaking_cfg(peaking_cfg),
        .delay_cfg(delay_cfg),
        .pll_cfg(pll_cfg),
        .decoded(DECODED)
    );

endmodule

`default_nettype wire

// >>> testbench/position_capture_regs_assertions.sv
`default_nettype none

module position_capture_regs_assertions
    import video_regs_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Host bus
    input wire logic [7:0] AD_I,
    input wire logic [7:0] AD_O,
    input wire logic AD_OE,
    input wire logic ALE,
    input wire logic WR_N,
    input wire logic RD_N,
    // Events and pins
    input wire irq_events_type IRQ_EVENTS,
    input wire logic GATE_ENABLE,
    input wire logic ACQ_RESET_PULSE,
    input wire logic ACQ_RESET_O,
    input wire logic ACQ_RESET_OE,
    input wire logic ACQ_CLOCK_OE,
    input wire logic DISP_INTERRUPT_PIN
);
    logic [7:0] addr;
    logic rd_prev;
    logic wr_prev;
    logic rd_go;
    logic wr_go;

    // Latched address and strobe history
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            addr <= 8'h00;
        end else if (ALE) begin
            addr <= AD_I;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
        end else begin
            rd_prev <= RD_N;
            wr_prev <= WR_N;
        end
    end

    assign rd_go = !ALE && !RD_N && rd_prev;
    assign wr_go = !ALE && !WR_N && wr_prev;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    sequence read_taken;
        rd_go ##1 (!RD_N && !ALE);
    endsequence

    sequence status_read;
        rd_go && addr[1:0] == 2'b01;
    endsequence

    chk_reset_gate: assert property (ACQ_RESET_OE |-> !ACQ_CLOCK_OE)
        else $error("reset driver on with clock driver");
    chk_pulse_copy: assert property ($past(RSTN) |-> ACQ_RESET_O == $past(ACQ_RESET_PULSE))
        else $error("reset pulse not copied");
    chk_bus_release: assert property (AD_OE |-> !RD_N && !ALE)
        else $error("bus driven outside read");
    chk_read_drive: assert property (read_taken |-> AD_OE)
        else $error("bus not driven in read");
    chk_read_hold: assert property (AD_OE && $past(AD_OE) |-> $stable(AD_O))
        else $error("read byte changed");
    chk_status_live: assert property (status_read |=> AD_O[ST_GATE] == $past(GATE_ENABLE)
        && AD_O[ST_DISPLAY] == $past(DISP_INTERRUPT_PIN))
        else $error("status byte wrong");
    chk_oe_write: assert property ($changed(ACQ_CLOCK_OE) || $changed(ACQ_RESET_OE)
        |-> $past(wr_go && addr == ADDR_IRQ_ENABLES))
        else $error("enable changed without write");
    chk_disp_set: assert property (IRQ_EVENTS.display_irq |=> DISP_INTERRUPT_PIN)
        else $error("display pending not set");
    chk_disp_clear: assert property ($fell(DISP_INTERRUPT_PIN)
        |-> $past(wr_go && addr == ADDR_CLEAR_DISPLAY))
        else $error("display pending dropped");
endmodule

bind position_capture_regs position_capture_regs_assertions chk_inst (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .AD_I(AD_I), .AD_O(AD_O), .AD_OE(AD_OE), .ALE(ALE),
    .WR_N(WR_N), .RD_N(RD_N), .IRQ_EVENTS(IRQ_EVENTS), .GATE_ENABLE(GATE_ENABLE),
    .ACQ_RESET_PULSE(ACQ_RESET_PULSE), .ACQ_RESET_O(ACQ_RESET_O),
    .ACQ_RESET_OE(ACQ_RESET_OE), .ACQ_CLOCK_OE(ACQ_CLOCK_OE),
    .DISP_INTERRUPT_PIN(DISP_INTERRUPT_PIN)
);

`default_nettype wire

// >>> testbench/host_bus_model.sv
`default_nettype none

module host_bus_model (
    // Bus pins
    input wire logic clk,
    input wire logic [7:0] bus_in,
    input wire logic bus_oe,
    output logic [7:0] bus_out,
    output logic ale,
    output logic wr_n,
    output logic rd_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_out = 8'h00;
        ale = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
    end

    task automatic put_addr(input logic [7:0] a);
        @(posedge clk);
        #2;
        ale = 1'b1;
        bus_out = a;
        @(posedge clk);
        #2;
        ale = 1'b0;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        put_addr(a);
        wr_n = 1'b0;
        bus_out = d;
        repeat (2) @(posedge clk);
        #2;
        wr_n = 1'b1;
        bus_out = ~d;
        @(posedge clk);
        #2;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
        put_addr(a);
        rd_n = 1'b0;
        bus_out = ~a;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = (bus_oe === 1'b1);
            d = bus_in;
        end
        #2;
        rd_n = 1'b1;
        bus_out = a;
        @(posedge clk);
        #2;
    endtask
endmodule

`default_nettype wire

// >>> testbench/position_capture_and_control_fields_tb.sv
`default_nettype none

module position_capture_and_control_fields_tb;
    import video_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rstn, ale, wr_n, rd_n, ad_oe, acq_v, disp_v, inset, gate, arp, drp;
    logic aro, aroe, dro, droe, acoe, dcoe, clamp, airq, dirq, exp;
    logic [7:0] ad_i, ad_o;
    counters_type cnt;
    irq_events_type ev;
    decoded_type dec;
    int fails = 0;
    int checked = 0;
    logic [3:0] pk [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
    logic [7:0] cr [4] = '{8'h12, 8'h34, 8'h78, 8'h00};
    logic [11:0] cl [4] = '{12'h800, 12'h6C0, 12'h600, 12'h510};

    position_capture_regs DUT (
        .CLK_SYS(clk), .RSTN(rstn), .AD_I(ad_i), .AD_O(ad_o), .AD_OE(ad_oe), .ALE(ale),
        .WR_N(wr_n), .RD_N(rd_n), .COUNTERS(cnt), .ACQ_VERTICAL_PULSE(acq_v),
        .DISP_VERTICAL_PULSE(disp_v), .INSET_PICTURE_INPUT(inset), .IRQ_EVENTS(ev),
        .GATE_ENABLE(gate), .ACQ_RESET_PULSE(arp), .DISP_RESET_PULSE(drp), .ACQ_RESET_O(aro),
        .ACQ_RESET_OE(aroe), .DISP_RESET_O(dro), .DISP_RESET_OE(droe), .ACQ_CLOCK_OE(acoe),
        .DISP_CLOCK_OE(dcoe), .CLAMP_PULSE(clamp), .ACQ_INTERRUPT_PIN(airq),
        .DISP_INTERRUPT_PIN(dirq), .DECODED(dec)
    );

    host_bus_model host (
        .clk(clk), .bus_in(ad_o), .bus_oe(ad_oe), .bus_out(ad_i), .ale(ale), .wr_n(wr_n),
        .rd_n(rd_n)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic step;
        @(posedge clk);
        #2;
    endtask

    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            fails++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        host.read_reg(a, d, ok);
        if (!ok) begin
            fails++;
            $display("unexpected %0t read timed out", $time);
            finish_test;
        end else chk((d & m) === e, $sformatf("read %h gave %h", a, d));
    endtask

    task automatic t_enables;
        chk({aroe, acoe, droe, dcoe, clamp, airq, dirq} === 7'h04, "idle pins");
        chk(dec === decoded_type'{4'h0, 4'h0, 4'h1, 4'h2, 4'hE, 4'hD, 12'h800}, "decode");
        for (int b = 4; b < 8; b++) begin
            wr(ADDR_IRQ_ENABLES, 8'(1 << b));
            chk({dcoe, droe, acoe, aroe} === 4'(1 << (b - 4)), "pin enable");
        end
        wr(ADDR_IRQ_ENABLES, 8'h30);
        chk(aroe === 1'b0, "reset driver kept off");
        arp = 1'b1;
        drp = 1'b1;
        step;
        arp = 1'b0;
        drp = 1'b0;
        chk(aro === 1'b1 && dro === 1'b1, "reset pulse out");
        $display("test enables done");
    endtask

    task automatic t_status;
        wr(ADDR_IRQ_ENABLES, 8'h02);
        gate = 1'b1;
        ev = 4'hF;
        step;
        ev = 4'h0;
        step;
        chk(airq === 1'b1 && dirq === 1'b1, "pins set");
        rd(8'h41, 8'h2F, 8'h2F);
        wr(ADDR_CLEAR_BURST, 8'h00);
        chk(airq === 1'b0, "burst cleared");
        rd(ADDR_COMBINED_STATUS, 8'h0F, 8'h0E);
        wr(ADDR_IRQ_ENABLES, 8'h04);
        chk(airq === 1'b1, "inset enabled");
        wr(ADDR_CLEAR_INSET, 8'h00);
        rd(ADDR_COMBINED_STATUS, 8'h0F, 8'h0A);
        wr(ADDR_IRQ_ENABLES, 8'h08);
        chk(airq === 1'b1, "blank enabled");
        wr(ADDR_CLEAR_BLANK_ACQ, 8'h00);
        chk(airq === 1'b0, "blank cleared");
        rd(ADDR_COMBINED_STATUS, 8'h0F, 8'h08);
        wr(ADDR_CLEAR_DISPLAY, 8'h00);
        gate = 1'b0;
        rd(ADDR_COMBINED_STATUS, 8'h2F, 8'h00);
        $display("test status done");
    endtask

    task automatic t_capture;
        cnt = '{9'h1A5, 8'h3C, 9'h15A, 8'hC3};
        acq_v = 1'b1;
        step;
        acq_v = 1'b0;
        cnt = '{9'h0F0, 8'h11, 9'h0E1, 8'h22};
        disp_v = 1'b1;
        step;
        disp_v = 1'b0;
        cnt = '{9'h000, 8'h00, 9'h000, 8'h00};
        rd(ADDR_ACQ_H_CAPTURE, 8'hFF, 8'h3C);
        rd(ADDR_ACQ_V_CAPTURE, 8'hFF, 8'hA5);
        rd(ADDR_DISP_H_CAPTURE, 8'hFF, 8'h22);
        rd(ADDR_DISP_V_CAPTURE, 8'hFF, 8'hE1);
        rd(ADDR_COMBINED_STATUS, 8'h50, 8'h10);
        cnt = '{9'h0B4, 8'h5A, 9'h1C3, 8'h6B};
        wr(ADDR_SAMPLE, 8'h00);
        cnt.acq_horizontal_counter = 8'h47;
        inset = 1'b1;
        step;
        cnt.acq_horizontal_counter = 8'h93;
        inset = 1'b0;
        step;
        rd(ADDR_ACQ_H_CAPTURE, 8'hFF, 8'h5A);
        // Capture lands on the read strobe edge
        fork
            rd(ADDR_ACQ_H_CAPTURE, 8'hFF, 8'h5A);
            begin
                repeat (2) step;
                cnt.acq_horizontal_counter = 8'hEE;
                acq_v = 1'b1;
                step;
                acq_v = 1'b0;
            end
        join
        rd(ADDR_ACQ_H_CAPTURE, 8'hFF, 8'hEE);
        rd(ADDR_ACQ_V_CAPTURE, 8'hFF, 8'hB4);
        rd(ADDR_DISP_H_CAPTURE, 8'hFF, 8'h6B);
        rd(ADDR_DISP_V_CAPTURE, 8'hFF, 8'hC3);
        rd(ADDR_COMBINED_STATUS, 8'h50, 8'h40);
        rd(ADDR_INSET_RISE, 8'hFF, 8'h47);
        rd(ADDR_INSET_FALL, 8'hFF, 8'h93);
        $display("test capture done");
    endtask

    task automatic t_clamp_decode;
        wr(ADDR_CLAMP_RISE, 8'h30);
        wr(ADDR_CLAMP_FALL, 8'h20);
        exp = 1'b0;
        for (int i = 8'h20; i < 8'h40; i++) begin
            cnt.acq_horizontal_counter = 8'(i);
            step;
            exp = (i == 8'h30) ? 1'b1 : ((i == 8'h20) ? 1'b0 : exp);
            chk(clamp === exp, "clamp edge");
        end
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PEAKING, 8'(i * 21));
            wr(ADDR_PLL, 8'(i << 2));
            chk(dec.peak_a_eighths === pk[i] && dec.peak_b_eighths === pk[i], "peak");
            chk({dec.coring_pos, dec.coring_neg} === cr[i], "coring");
            chk(dec.clocks_per_line === cl[i], "divider");
        end
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_DELAY, 8'(i * 36));
            chk(dec.uv_delay === 4'(i - 2) && dec.y_delay === 4'(i - 3), "delays");
        end
        $display("test clamp and decode done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        {acq_v, disp_v, inset, gate, arp, drp} = 6'h00;
        cnt = '0;
        ev = 4'h0;
        repeat (5) @(posedge clk);
        #2;
        rstn = 1'b1;
        step;
        t_enables;
        t_status;
        t_capture;
        t_clamp_decode;
        finish_test;
    end
endmodule

`default_nettype wire
